// >>> logic/ccb_pkg.sv
package ccb_pkg;

    // ------------------------------------------------------------
    // Sizes and register map
    // ------------------------------------------------------------
    localparam int          FIFO_BYTES   = 64;
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_COUNT   = 8'h08;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam int          CTRL_GO0_BIT = 0;
    localparam int          CTRL_GO1_BIT = 1;
    localparam int          DMA_CH_C2M   = 0;
    localparam int          DMA_CH_M2C   = 1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        hdr;
        logic [23:0] data;
    } ccb_wcmd_s;

    typedef enum logic [2:0] {
        WX_IDLE, WX_LOW, WX_MID, WX_HIGH, WX_DUMMY
    } ccb_wx_e;

    typedef enum logic [1:0] {
        RX_LOW, RX_MID, RX_HIGH
    } ccb_rx_e;

    typedef enum logic [1:0] {
        DM_IDLE, DM_REQ, DM_WAIT
    } ccb_dm_e;

endpackage : ccb_pkg

// >>> logic/ccb_bridge.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ccb_bridge
    import ccb_pkg::*;
#(
    parameter int DEPTH = FIFO_BYTES
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Crate dataway side
    input  wire logic        cam_s1,
    input  wire logic        cam_write,
    input  wire logic        cam_read,
    input  wire ccb_wcmd_s   cam_wcmd,
    output logic             cam_q,
    output logic [23:0]      cam_rdata,
    output logic             read_output_enable,
    output logic             read_data_valid,
    output logic             write_pending_flag,
    // Dma controller side, channel 0 and 1
    output logic [1:0]       dma_req,
    input  wire logic [1:0]  dma_ack,
    input  wire logic [1:0]  dma_done,
    input  wire logic        dma_transfer_strobe,
    output logic [7:0]       dma_rdata,
    input  wire logic [7:0]  dma_wdata,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);

    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Fifo storage, both directions
    // ------------------------------------------------------------
    logic [7:0]  c2m_mem [DEPTH];
    logic [7:0]  m2c_mem [DEPTH];
    logic [PW:0] c2m_wp_ff, c2m_rp_ff, m2c_wp_ff, m2c_rp_ff;
    logic [31:0] ctrl_ff;
    ccb_wx_e     wx_ff;
    ccb_rx_e     rx_ff;
    ccb_dm_e     dm0_ff, dm1_ff;
    logic [23:0] wreg_ff, rreg_ff;
    logic        hdr_ff;

    function automatic logic [PW:0] fcount(input logic [PW:0] w, input logic [PW:0] r);
        fcount = w - r;
    endfunction : fcount

    wire  c2m_full  = fcount(c2m_wp_ff, c2m_rp_ff) == DEPTH[PW:0];
    wire  c2m_empty = fcount(c2m_wp_ff, c2m_rp_ff) == '0;
    wire  m2c_full  = fcount(m2c_wp_ff, m2c_rp_ff) == DEPTH[PW:0];
    wire  m2c_empty = fcount(m2c_wp_ff, m2c_rp_ff) == '0;

    // Byte selected by the current shift phase; dummy byte is zero
    logic [7:0] shift_byte;
    always_comb begin
        case (wx_ff)
            WX_LOW:  shift_byte = wreg_ff[7:0];
            WX_MID:  shift_byte = wreg_ff[15:8];
            WX_HIGH: shift_byte = wreg_ff[23:16];
            default: shift_byte = 8'h00;
        endcase
    end
    wire fifo_shift_in_pulse = (wx_ff != WX_IDLE) && !c2m_full;
    wire write_high_byte_enable = fifo_shift_in_pulse &&
        ((wx_ff == WX_HIGH && !hdr_ff) || wx_ff == WX_DUMMY);
    wire wr_accept = cam_s1 && cam_write && !write_pending_flag;
    wire rd_take   = cam_s1 && cam_read && read_data_valid;
    wire rd_shift  = !read_data_valid && !m2c_empty;
    wire m2c_push  = dma_transfer_strobe && dma_ack[DMA_CH_M2C] && !m2c_full;
    wire c2m_pop   = dma_req[DMA_CH_C2M] && dma_ack[DMA_CH_C2M];

    // ------------------------------------------------------------
    // Write manager and crate-to-cpu shifter
    // ------------------------------------------------------------
    // Pending write blocks new latching so held bytes are not lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wx_ff              <= WX_IDLE;
            wreg_ff            <= 24'h00_0000;
            hdr_ff             <= 1'b0;
            write_pending_flag <= 1'b0;
        end else begin
            if (wr_accept) begin
                wreg_ff            <= cam_wcmd.data;
                hdr_ff             <= cam_wcmd.hdr;
                wx_ff              <= WX_LOW;
                write_pending_flag <= 1'b1;
            end else if (fifo_shift_in_pulse) begin
                case (wx_ff)
                    WX_LOW:  wx_ff <= WX_MID;
                    WX_MID:  wx_ff <= WX_HIGH;
                    WX_HIGH: wx_ff <= hdr_ff ? WX_DUMMY : WX_IDLE;
                    default: wx_ff <= WX_IDLE;
                endcase
                if (write_high_byte_enable) begin
                    write_pending_flag <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c2m_wp_ff <= '0;
            c2m_rp_ff <= '0;
        end else begin
            if (fifo_shift_in_pulse) begin
                c2m_mem[c2m_wp_ff[PW-1:0]] <= shift_byte;
                c2m_wp_ff <= c2m_wp_ff + 1'b1;
            end
            if (c2m_pop) begin
                c2m_rp_ff <= c2m_rp_ff + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Cpu-to-crate fifo and read registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m2c_wp_ff <= '0;
            m2c_rp_ff <= '0;
        end else begin
            if (m2c_push) begin
                m2c_mem[m2c_wp_ff[PW-1:0]] <= dma_wdata;
                m2c_wp_ff <= m2c_wp_ff + 1'b1;
            end
            if (rd_shift) begin
                m2c_rp_ff <= m2c_rp_ff + 1'b1;
            end
        end
    end

    // Read sequencer: valid only after the high byte clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ff           <= RX_LOW;
            rreg_ff         <= 24'h00_0000;
            read_data_valid <= 1'b0;
        end else begin
            if (rd_shift) begin
                case (rx_ff)
                    RX_LOW: begin
                        rreg_ff[7:0] <= m2c_mem[m2c_rp_ff[PW-1:0]];
                        rx_ff        <= RX_MID;
                    end
                    RX_MID: begin
                        rreg_ff[15:8] <= m2c_mem[m2c_rp_ff[PW-1:0]];
                        rx_ff         <= RX_HIGH;
                    end
                    default: begin
                        rreg_ff[23:16]  <= m2c_mem[m2c_rp_ff[PW-1:0]];
                        rx_ff           <= RX_LOW;
                        read_data_valid <= 1'b1;
                    end
                endcase
            end else if (rd_take) begin
                read_data_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Crate answers
    // ------------------------------------------------------------
    // Q only for accepted writes and reads with valid data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cam_q              <= 1'b0;
            cam_rdata          <= 24'h00_0000;
            read_output_enable <= 1'b0;
        end else begin
            cam_q              <= wr_accept || rd_take;
            read_output_enable <= rd_take;
            cam_rdata          <= rd_take ? rreg_ff : 24'h00_0000;
        end
    end

    // ------------------------------------------------------------
    // Dma request control, channel 0 drains, channel 1 fills
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dm0_ff    <= DM_IDLE;
            dma_rdata <= 8'h00;
        end else begin
            case (dm0_ff)
                DM_IDLE: if (ctrl_ff[CTRL_GO0_BIT] && !c2m_empty) begin
                    dm0_ff <= DM_REQ;
                end
                DM_REQ: if (dma_ack[DMA_CH_C2M]) begin
                    dma_rdata <= c2m_mem[c2m_rp_ff[PW-1:0]];
                    dm0_ff    <= DM_WAIT;
                end
                DM_WAIT: if (dma_done[DMA_CH_C2M]) begin
                    dm0_ff <= DM_IDLE;
                end else if (!dma_ack[DMA_CH_C2M]) begin
                    dm0_ff <= DM_IDLE;
                end
                default: dm0_ff <= DM_IDLE;
            endcase
        end
    end

    // Hold back the next request until the ack is released or done is seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dm1_ff <= DM_IDLE;
        end else begin
            case (dm1_ff)
                DM_IDLE: if (ctrl_ff[CTRL_GO1_BIT] && !m2c_full) begin
                    dm1_ff <= DM_REQ;
                end
                DM_REQ: if (dma_ack[DMA_CH_M2C]) begin
                    dm1_ff <= DM_WAIT;
                end
                DM_WAIT: if (dma_done[DMA_CH_M2C]) begin
                    dm1_ff <= DM_IDLE;
                end else if (!dma_ack[DMA_CH_M2C]) begin
                    dm1_ff <= DM_IDLE;
                end
                default: dm1_ff <= DM_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_req <= 2'b00;
        end else begin
            dma_req[DMA_CH_C2M] <= (dm0_ff == DM_REQ) && !dma_ack[DMA_CH_C2M] &&
                                   ctrl_ff[CTRL_GO0_BIT];
            dma_req[DMA_CH_M2C] <= (dm1_ff == DM_REQ) && !dma_ack[DMA_CH_M2C] &&
                                   ctrl_ff[CTRL_GO1_BIT];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data taken together in one cycle; order is free
    wire wr_go = s_awvalid && s_wvalid && !s_bvalid;
    wire rd_go = s_arvalid && !s_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            ctrl_ff   <= CTRL_RESET;
        end else begin
            s_awready <= wr_go && !s_awready;
            s_wready  <= wr_go && !s_awready;
            if (wr_go && !s_awready) begin
                s_bvalid <= 1'b1;
                s_bresp  <= (s_awaddr == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
                if (s_awaddr == ADDR_CTRL && s_wstrb[0]) begin
                    ctrl_ff[7:0] <= s_wdata[7:0];
                end
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= RESP_OKAY;
        end else begin
            s_arready <= rd_go && !s_arready;
            if (rd_go && !s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp  <= RESP_OKAY;
                case (s_araddr)
                    ADDR_CTRL:   s_rdata <= ctrl_ff;
                    ADDR_STATUS: s_rdata <= {24'h00_0000, dma_req, dm1_ff != DM_IDLE,
                                  dm0_ff != DM_IDLE, read_data_valid,
                                  write_pending_flag, m2c_empty, c2m_empty};
                    ADDR_COUNT:  s_rdata <= {16'h0000, 1'b0, fcount(m2c_wp_ff, m2c_rp_ff),
                                  1'b0, fcount(c2m_wp_ff, c2m_rp_ff)};
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_write_no_q: assert property (@(posedge aclk) disable iff (!aresetn)
        (cam_s1 && cam_write && write_pending_flag && !cam_read) |=> !cam_q)
        else $error("Q given to write while pending");
    chk_write_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (cam_s1 && cam_write && write_pending_flag) |=> $stable(wreg_ff))
        else $error("Pending write data overwritten");
    chk_pend_set: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_accept |=> write_pending_flag && wx_ff == WX_LOW)
        else $error("Accepted write not pending");
    chk_pend_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        write_high_byte_enable |=> !write_pending_flag)
        else $error("Pending flag not cleared");
    chk_read_q: assert property (@(posedge aclk) disable iff (!aresetn)
        (cam_s1 && cam_read && read_data_valid) |=> cam_q && read_output_enable)
        else $error("Valid read without Q");
    chk_read_noq: assert property (@(posedge aclk) disable iff (!aresetn)
        (cam_s1 && cam_read && !read_data_valid && !cam_write) |=> !cam_q && !read_output_enable)
        else $error("Read before valid answered");
    chk_valid_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_shift && rx_ff == RX_HIGH) |=> read_data_valid)
        else $error("High byte did not set valid");
    chk_done_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (dm1_ff == DM_WAIT && dma_done[DMA_CH_M2C]) |=> dm1_ff == DM_IDLE ##1 !dma_req[DMA_CH_M2C])
        else $error("Done did not idle channel 1");
    chk_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        fcount(c2m_wp_ff, c2m_rp_ff) <= DEPTH[PW:0] && fcount(m2c_wp_ff, m2c_rp_ff) <= DEPTH[PW:0])
        else $error("Fifo count above depth");

endmodule : ccb_bridge

`default_nettype wire

// >>> testbench/ccb_dma_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Dma controller model: channel 0 drains, channel 1 fills
// ------------------------------------------------------------
module ccb_dma_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Bridge side
    input  wire logic [1:0] dma_req,
    input  wire logic [7:0] dma_rdata,
    output logic [1:0]      dma_ack,
    output logic [1:0]      dma_done,
    output logic            dma_transfer_strobe,
    output logic [7:0]      dma_wdata,
    // Programmed byte counts and extra ack cycles
    input  wire logic [7:0] n0,
    input  wire logic [7:0] n1,
    input  wire logic [3:0] dly
);
    logic [7:0] got0[$];
    logic [7:0] c0  = 8'h00;
    logic [7:0] c1  = 8'h00;
    logic [7:0] pat = 8'h10;
    logic       ack0 = 1'b0, ack1 = 1'b0, done0 = 1'b0, done1 = 1'b0;
    logic       stb1 = 1'b0;
    logic [7:0] wbyte = 8'h5A;

    // One driver per line: the channel 1 process owns strobe and byte
    assign dma_ack             = {ack1, ack0};
    assign dma_done            = {done1, done0};
    assign dma_transfer_strobe = stb1;
    assign dma_wdata           = wbyte;

    // Channel 0: byte is taken after the first ack cycle, done rides the last ack
    always begin : ch0
        @(posedge aclk);
        if (aresetn && dma_req[0]) begin
            ack0 <= 1'b1;
            @(posedge aclk);
            #1;
            got0.push_back(dma_rdata);
            c0 = c0 + 8'h01;
            if (c0 == n0) begin
                done0 <= 1'b1;
                c0 = 8'h00;
            end
            repeat (dly) @(posedge aclk);
            @(posedge aclk);
            ack0  <= 1'b0;
            done0 <= 1'b0;
        end
    end

    // Channel 1: strobe only in the last ack cycle, so a slow ack delays the byte
    always begin : ch1
        @(posedge aclk);
        if (aresetn && dma_req[1]) begin
            ack1  <= 1'b1;
            wbyte <= pat;
            repeat (dly) @(posedge aclk);
            @(posedge aclk);
            stb1 <= 1'b1;
            c1 = c1 + 8'h01;
            if (c1 == n1) begin
                done1 <= 1'b1;
                c1 = 8'h00;
            end
            @(posedge aclk);
            ack1  <= 1'b0;
            done1 <= 1'b0;
            stb1  <= 1'b0;
            wbyte <= ~pat; // Released line must not keep the byte
            pat = pat + 8'h01;
        end
    end
endmodule : ccb_dma_model

`default_nettype wire

// >>> testbench/test_crate_to_cpu_fifo_bridge.sv
`timescale 1ns/1ps
`default_nettype none

module test_crate_to_cpu_fifo_bridge import ccb_pkg::*;;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        cam_s1 = 1'b0, cam_write = 1'b0, cam_read = 1'b0;
    ccb_wcmd_s   cam_wcmd = '0;
    logic        cam_q, read_output_enable, read_data_valid, write_pending_flag;
    logic [23:0] cam_rdata;
    logic [1:0]  dma_req, dma_ack, dma_done;
    logic        dma_transfer_strobe;
    logic [7:0]  dma_rdata, dma_wdata;
    logic [7:0]  s_awaddr = '0, s_araddr = '0, n0 = 8'h03, n1 = 8'h00;
    logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic [31:0] s_wdata = '0;
    logic [3:0]  s_wstrb = 4'hF, dly = 4'h0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    logic [31:0] s_rdata;
    int          errors = 0, samples_checked = 0, cyc = 0;

    ccb_bridge ccb_bridge_inst (.aclk, .aresetn, .cam_s1, .cam_write, .cam_read, .cam_wcmd,
        .cam_q, .cam_rdata, .read_output_enable, .read_data_valid, .write_pending_flag,
        .dma_req, .dma_ack, .dma_done, .dma_transfer_strobe, .dma_rdata, .dma_wdata,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready);
    ccb_dma_model ccb_dma_model_inst (.aclk, .aresetn, .dma_req, .dma_rdata, .dma_ack,
        .dma_done, .dma_transfer_strobe, .dma_wdata, .n0, .n1, .dly);

    // 250 MHz clock and a hang guard well above the run length
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic results;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Bus and crate cycles
    // ------------------------------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1 && n < 50);
        s_bready <= 1'b0;
        check(s_bvalid, 1'b1, "bvalid");
        check(s_bresp, er, "bresp");
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_arready) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1 && n < 50);
        s_rready <= 1'b0;
        check(s_rvalid, 1'b1, "rvalid");
        check(s_rdata, ed, "rdata");
        check(s_rresp, er, "rresp");
    endtask : axr

    // One S1 strobe; Q, and for reads the enable and read lines, are looked at in the answer cycle
    task automatic crate(input logic wr, input ccb_wcmd_s c, input logic eq, input logic [23:0] ed);
        @(posedge aclk);
        cam_s1    <= 1'b1;
        cam_write <= wr;
        cam_read  <= !wr;
        cam_wcmd  <= c;
        @(posedge aclk);
        cam_s1 <= 1'b0;
        #1;
        check(cam_q, eq, "q");
        if (!wr) begin
            check(read_output_enable, eq, "oe");
            check(cam_rdata, ed, "read lines");
        end
    endtask : crate

    // Wait for a flag: rd picks read_data_valid, otherwise the pending flag
    task automatic till(input logic rd, input logic v);
        int n = 0;
        while ((rd ? read_data_valid : write_pending_flag) !== v && n < 600) begin
            @(posedge aclk);
            n++;
        end
        check(rd ? read_data_valid : write_pending_flag, v, "wait");
    endtask : till

    // Bytes drained on channel 0 must come out in this order, low byte first
    task automatic expect0(input logic [31:0] b, input int k);
        int n = 0;
        while (ccb_dma_model_inst.got0.size() < k && n < 200) begin
            @(posedge aclk);
            n++;
        end
        check(ccb_dma_model_inst.got0.size(), k, "drained count");
        for (int i = 0; i < k; i++) begin
            check(ccb_dma_model_inst.got0.pop_front(), b[8*i+:8], "drained byte");
        end
    endtask : expect0

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        check({cam_q, dma_req, write_pending_flag, read_data_valid}, 0, "reset outputs");
        axr(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        axr(ADDR_STATUS, 32'h0000_0003, RESP_OKAY);
        axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        axr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        axw(ADDR_STATUS, 32'h0000_00FF, RESP_SLVERR);
        axr(8'hFC, 32'h0000_0000, RESP_SLVERR);
        check(dma_req, 2'h0, "idle with empty fifo");
    endtask : t_regs

    task automatic t_write;
        crate(1'b1, {1'b0, 24'hC3B2A1}, 1'b1, 24'h0);
        check(write_pending_flag, 1'b1, "pending set");
        till(1'b0, 1'b0);
        expect0(32'h00C3B2A1, 3);
        repeat (4) @(posedge aclk);
        check(dma_req[0], 1'b0, "idle after done");
    endtask : t_write

    // Second write lands while the first is still pending
    task automatic t_pend;
        crate(1'b1, {1'b0, 24'h332211}, 1'b1, 24'h0);
        crate(1'b1, {1'b0, 24'h665544}, 1'b0, 24'h0);
        expect0(32'h00332211, 3);
        repeat (20) @(posedge aclk);
        check(ccb_dma_model_inst.got0.size(), 0, "no stray bytes");
        n0 <= 8'h04;
        crate(1'b1, {1'b1, 24'h998877}, 1'b1, 24'h0);
        expect0(32'h00998877, 4);
    endtask : t_pend

    // Slow acknowledges on channel 1 feed the read registers
    task automatic t_read;
        crate(1'b0, '0, 1'b0, 24'h0);
        n1  <= 8'h05;
        dly <= 4'h3;
        axw(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
        till(1'b1, 1'b1);
        crate(1'b0, '0, 1'b1, 24'h121110);
        check(read_data_valid, 1'b0, "valid cleared");
        till(1'b1, 1'b1);
        crate(1'b0, '0, 1'b1, 24'h151413);
    endtask : t_read

    task automatic t_full;
        repeat (1500) @(posedge aclk);
        axr(ADDR_COUNT, FIFO_BYTES * 256, RESP_OKAY);
        check(dma_req[1], 1'b0, "no request when full");
    endtask : t_full

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_write();
        t_pend();
        t_read();
        t_full();
        results();
    end
endmodule : test_crate_to_cpu_fifo_bridge

`default_nettype wire
